//--- bench/adrm_decoder_model.sv
// decoder model: supplies signed samples and drives the external reset pin
// assumes it runs on the device CLOCK and watches the system clock output
`timescale 1ns/100ps
module adrm_decoder_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // device pins
  input wire logic sck,
  input wire logic take,
  output logic ext_reset_n,
  output logic [adrm_pkg::DW-1:0] data,
  // bench control
  input wire logic hold_reset,
  input wire logic [adrm_pkg::DW-1:0] next_val,
  output int sck_rises
);
  logic sck_r;

  // ----------------------------------------------------------------
  // pins: reset held low on request, next sample after each take
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_reset_n <= 1'b0;
      data <= 16'h0000;
    end else begin
      ext_reset_n <= !hold_reset;
      if (take === 1'b1) begin
        data <= next_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // decoder counts rising edges of the system clock output, sampled on CLOCK
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_r <= 1'b0;
      sck_rises <= 0;
    end else begin
      sck_r <= sck;
      if (sck === 1'b1 && sck_r === 1'b0) begin
        sck_rises <= sck_rises + 1;
      end
    end
  end
endmodule

//--- bench/audio_dac_reset_and_modulator_tb.sv
// self-checking bench for the converter digital path
// assumes the decoder model on the sample side and a 100 MHz CLOCK
`timescale 1ns/100ps
module audio_dac_reset_and_modulator_tb;
  logic CLOCK = 1'b0;
  logic RST_B = 1'b0;
  logic EXTERNAL_RESET_N;
  logic CLOCK_RATIO_SELECT = 1'b0;
  logic SYSTEM_CLOCK_OUTPUT;
  logic [adrm_pkg::DW-1:0] SAMPLE_DATA;
  logic SAMPLE_TAKEN;
  logic [adrm_pkg::LVL_W-1:0] MOD_LEVEL;
  logic MOD_STROBE;
  logic OUTPUT_VALID;
  logic hold_reset = 1'b1;
  logic [adrm_pkg::DW-1:0] next_val = 16'h0000;
  logic [adrm_pkg::DW-1:0] take_dat;
  logic prev_valid = 1'b0;
  int sck_rises;
  int cyc = 0;
  int takes = 0;
  int take_cyc = 0;
  int strobes = 0;
  int lvl_sum = 0;
  int n_fail = 0;
  int compares = 0;
  int q[$];

  adrm_top dut (.CLOCK(CLOCK), .RST_B(RST_B), .EXTERNAL_RESET_N(EXTERNAL_RESET_N),
    .CLOCK_RATIO_SELECT(CLOCK_RATIO_SELECT), .SYSTEM_CLOCK_OUTPUT(SYSTEM_CLOCK_OUTPUT),
    .SAMPLE_DATA(SAMPLE_DATA), .SAMPLE_TAKEN(SAMPLE_TAKEN), .MOD_LEVEL(MOD_LEVEL),
    .MOD_STROBE(MOD_STROBE), .OUTPUT_VALID(OUTPUT_VALID));

  adrm_decoder_model partner (.clk(CLOCK), .rst_b(RST_B), .sck(SYSTEM_CLOCK_OUTPUT), .take(SAMPLE_TAKEN),
    .ext_reset_n(EXTERNAL_RESET_N), .data(SAMPLE_DATA), .hold_reset(hold_reset), .next_val(next_val),
    .sck_rises(sck_rises));

  initial begin
    forever #5 CLOCK = ~CLOCK;
  end

  // ----------------------------------------------------------------
  // compare tasks and verdict
  // ----------------------------------------------------------------
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_lvl(input logic [2:0] got, input logic [2:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic results();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wait_take();
    int t0;
    t0 = takes;
    for (int i = 0; i < 3000 && takes == t0; i++) @(negedge CLOCK);
  endtask

  // ----------------------------------------------------------------
  // event counters, output monitor and watchdog
  // ----------------------------------------------------------------
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (SAMPLE_TAKEN === 1'b1) begin
      takes <= takes + 1;
      take_cyc <= cyc;
      take_dat <= SAMPLE_DATA;
    end
    if (MOD_STROBE === 1'b1) begin
      strobes <= strobes + 1;
      lvl_sum <= lvl_sum + int'(MOD_LEVEL) - 2;
    end
    if (cyc == 100000) begin
      n_fail++;
      results();
    end
  end

  always @(negedge CLOCK) begin
    if (OUTPUT_VALID !== 1'b1 && prev_valid !== 1'b1) chk_lvl(MOD_LEVEL, adrm_pkg::LVL_MID);
    chk_bit(MOD_LEVEL <= adrm_pkg::LVL_MAX, 1'b1);
    if (SAMPLE_TAKEN === 1'b1) chk_bit(OUTPUT_VALID, 1'b1);
    prev_valid = OUTPUT_VALID;
  end

  // ----------------------------------------------------------------
  // main sequence: both clock ratios
  // ----------------------------------------------------------------
  initial begin
    int ratio;
    int strb;
    int c0;
    int e0;
    int s0;
    int l0;
    int v;
    int exp;
    void'($urandom(99852));
    repeat (5) @(negedge CLOCK);
    RST_B = 1'b1;
    for (int r = 0; r < 2; r++) begin
      ratio = (r == 0) ? 384 : 256;
      strb = (r == 0) ? 48 : 64;
      hold_reset = 1'b1;
      CLOCK_RATIO_SELECT = r[0];
      repeat (6 + $urandom_range(0, 7)) @(negedge CLOCK);
      chk_bit(OUTPUT_VALID, 1'b0);
      hold_reset = 1'b0;
      repeat (500) @(negedge CLOCK);
      chk_bit(OUTPUT_VALID, 1'b0);
      hold_reset = 1'b1;
      repeat (4) @(negedge CLOCK);
      hold_reset = 1'b0;
      e0 = sck_rises;
      for (int i = 0; i < 10000 && OUTPUT_VALID !== 1'b1; i++) @(negedge CLOCK);
      chk_cnt(sck_rises - e0, 1020, 1028);
      wait_take();
      c0 = take_cyc;
      e0 = sck_rises;
      s0 = strobes;
      wait_take();
      chk_cnt(take_cyc - c0, 2083, 2084);
      chk_cnt(sck_rises - e0, ratio - 1, ratio + 1);
      chk_cnt(strobes - s0, strb - 1, strb + 1);
      v = $urandom_range(8000, 30000);
      if ($urandom_range(0, 1) == 1) v = -v;
      next_val = 16'(v);
      wait_take();
      wait_take();
      chk_bit(take_dat === 16'(v), 1'b1);
      q.push_back(v);
      c0 = take_cyc;
      for (int i = 0; i < 12 * 2084 && MOD_LEVEL === adrm_pkg::LVL_MID; i++) @(negedge CLOCK);
      chk_cnt(cyc - c0, 10 * 2083, 12 * 2084);
      for (int i = 0; i < 30000 && cyc - c0 < 12 * 2084; i++) @(negedge CLOCK);
      wait_take();
      s0 = strobes;
      l0 = lvl_sum;
      next_val = 16'h0000;
      wait_take();
      exp = (strobes - s0) * q.pop_front() / 32768;
      chk_cnt(lvl_sum - l0, exp - 6, exp + 6);
    end
    results();
  end
endmodule

//--- design/adrm_dsm.sv
// third-order five-level delta-sigma requantiser
// assumes step pulses at the modulator rate and hold from the reset sequencer
`timescale 1ns/100ps
module adrm_dsm (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic step,
  input wire logic hold,
  // data
  input wire logic signed [adrm_pkg::DW-1:0] x,
  output logic [adrm_pkg::LVL_W-1:0] level_r,
  output logic strobe_r
);

  // ----------------------------------------------------------------
  // error-feedback loop, noise transfer (1 - z^-1)^3
  // ----------------------------------------------------------------
  logic signed [adrm_pkg::DSM_W-1:0] e1_r, e2_r, e3_r;
  logic signed [adrm_pkg::DSM_W-1:0] v, q, err;

  always_comb begin
    v = adrm_pkg::DSM_W'(x >>> 1) + (e1_r <<< 1) + e1_r - (e2_r <<< 1) - e2_r + e3_r;
    q = (v + adrm_pkg::DSM_HALF) >>> adrm_pkg::DSM_QSH;
    if (q > adrm_pkg::DSM_AMP) begin
      q = adrm_pkg::DSM_AMP;
    end else if (q < -adrm_pkg::DSM_AMP) begin
      q = -adrm_pkg::DSM_AMP;
    end
    err = v - (q <<< adrm_pkg::DSM_QSH);
    if (err > adrm_pkg::DSM_ERR_LIM) begin
      err = adrm_pkg::DSM_ERR_LIM;
    end else if (err < -adrm_pkg::DSM_ERR_LIM) begin
      err = -adrm_pkg::DSM_ERR_LIM;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      e1_r <= '0;
      e2_r <= '0;
      e3_r <= '0;
    end else if (hold) begin
      e1_r <= '0;
      e2_r <= '0;
      e3_r <= '0;
    end else if (step) begin
      e1_r <= err;
      e2_r <= e1_r;
      e3_r <= e2_r;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      level_r <= adrm_pkg::LVL_MID;
      strobe_r <= 1'b0;
    end else begin
      strobe_r <= step;
      if (hold) begin
        level_r <= adrm_pkg::LVL_MID;
      end else if (step) begin
        level_r <= adrm_pkg::LVL_W'(q + adrm_pkg::DSM_AMP);
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_level_range: assert property (strobe_r |-> level_r <= adrm_pkg::LVL_MAX)
    else $error("modulator level outside five codes");
  a_hold_midpoint: assert property (hold |=> level_r == adrm_pkg::LVL_MID)
    else $error("held modulator not at midpoint");
  c_dsm_top_level: cover property (strobe_r && level_r == adrm_pkg::LVL_MAX);

endmodule

//--- design/adrm_top.sv
// converter digital path: clock generation, reset sequencing, 8x interpolation,
// fixed-latency alignment and the delta-sigma modulator
// assumes sample data come from logic on CLOCK; reset and ratio pins are asynchronous
`timescale 1ns/100ps
module adrm_top (
  // clock and power-on reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // pins
  input wire logic EXTERNAL_RESET_N,
  input wire logic CLOCK_RATIO_SELECT,
  output logic SYSTEM_CLOCK_OUTPUT,
  // sample input
  input wire logic [adrm_pkg::DW-1:0] SAMPLE_DATA,
  output logic SAMPLE_TAKEN,
  // modulator output
  output logic [adrm_pkg::LVL_W-1:0] MOD_LEVEL,
  output logic MOD_STROBE,
  output logic OUTPUT_VALID
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic rst_m_r, ext_rst_n_r, sel_m_r, sel_r;

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rst_m_r <= 1'b0;
      ext_rst_n_r <= 1'b0;
      sel_m_r <= 1'b0;
      sel_r <= 1'b0;
    end else begin
      rst_m_r <= EXTERNAL_RESET_N;
      ext_rst_n_r <= rst_m_r;
      sel_m_r <= CLOCK_RATIO_SELECT;
      sel_r <= sel_m_r;
    end
  end

  // ----------------------------------------------------------------
  // system clock generator
  // ----------------------------------------------------------------
  logic [adrm_pkg::NCO_W-1:0] acc_r, inc;
  logic [adrm_pkg::NCO_W:0] acc_sum;
  logic sys_en;

  assign inc = sel_r ? adrm_pkg::NCO_INC_HI : adrm_pkg::NCO_INC_LO;
  assign acc_sum = {1'b0, acc_r} + {1'b0, inc};
  assign sys_en = acc_sum[adrm_pkg::NCO_W];

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      acc_r <= '0;
      SYSTEM_CLOCK_OUTPUT <= 1'b0;
    end else begin
      acc_r <= acc_sum[adrm_pkg::NCO_W-1:0];
      SYSTEM_CLOCK_OUTPUT <= acc_r[adrm_pkg::NCO_W-1];
    end
  end

  // ----------------------------------------------------------------
  // rate dividers
  // ----------------------------------------------------------------
  logic [adrm_pkg::CNT_W-1:0] mod_cnt_r, ip_cnt_r, phase_r, mod_last, ip_last;
  logic mod_en, ip_en, samp_en;

  assign mod_last = sel_r ? adrm_pkg::MOD_DIV_HI : adrm_pkg::MOD_DIV_LO;
  assign ip_last = sel_r ? adrm_pkg::IP_DIV_HI : adrm_pkg::IP_DIV_LO;
  // exact match: a count left above a smaller limit wraps through zero
  assign mod_en = sys_en && mod_cnt_r == mod_last;
  assign ip_en = mod_en && ip_cnt_r == ip_last;
  assign samp_en = ip_en && phase_r == adrm_pkg::PH_LAST;

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      mod_cnt_r <= '0;
      ip_cnt_r <= '0;
      phase_r <= '0;
    end else begin
      if (sys_en) begin
        mod_cnt_r <= mod_en ? '0 : mod_cnt_r + 1'b1;
      end
      if (mod_en) begin
        ip_cnt_r <= ip_en ? '0 : ip_cnt_r + 1'b1;
      end
      if (ip_en) begin
        phase_r <= phase_r + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // reset sequencer
  // ----------------------------------------------------------------
  adrm_pkg::adrm_state_t st_r;
  logic [adrm_pkg::INIT_W-1:0] init_cnt_r;
  logic run;

  assign run = st_r == adrm_pkg::ADRM_ST_RUN;
  assign OUTPUT_VALID = run;

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      st_r <= adrm_pkg::ADRM_ST_RESET;
      init_cnt_r <= '0;
    end else if (!ext_rst_n_r) begin
      st_r <= adrm_pkg::ADRM_ST_RESET;
      init_cnt_r <= '0;
    end else begin
      case (st_r)
        adrm_pkg::ADRM_ST_RESET: begin
          st_r <= adrm_pkg::ADRM_ST_INIT;
          init_cnt_r <= '0;
        end
        adrm_pkg::ADRM_ST_INIT: begin
          if (sys_en) begin
            if (init_cnt_r == adrm_pkg::INIT_LAST) begin
              st_r <= adrm_pkg::ADRM_ST_RUN;
            end
            init_cnt_r <= init_cnt_r + 1'b1;
          end
        end
        adrm_pkg::ADRM_ST_RUN: begin
          st_r <= adrm_pkg::ADRM_ST_RUN;
        end
        default: begin
          st_r <= adrm_pkg::ADRM_ST_RESET;
          init_cnt_r <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // linear 8x interpolator
  // ----------------------------------------------------------------
  logic signed [adrm_pkg::DW-1:0] cur_r, prev_r, interp;
  logic signed [adrm_pkg::DW:0] diff;
  logic signed [adrm_pkg::DW+adrm_pkg::CNT_W+1:0] step_val;

  assign diff = (adrm_pkg::DW+1)'(cur_r) - (adrm_pkg::DW+1)'(prev_r);
  assign step_val = (diff * $signed({2'b00, phase_r} + 5'sd1)) >>> adrm_pkg::PH_SHIFT;
  assign interp = adrm_pkg::DW'(prev_r + step_val);
  assign SAMPLE_TAKEN = samp_en && run;

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      cur_r <= '0;
      prev_r <= '0;
    end else if (!run) begin
      cur_r <= '0;
      prev_r <= '0;
    end else if (samp_en) begin
      cur_r <= SAMPLE_DATA;
      prev_r <= cur_r;
    end
  end

  // ----------------------------------------------------------------
  // latency alignment line
  // ----------------------------------------------------------------
  logic signed [adrm_pkg::DW-1:0] dl_r [adrm_pkg::LAT_PAD];
  logic signed [adrm_pkg::DW-1:0] mod_in_r;

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < adrm_pkg::LAT_PAD; i++) begin
        dl_r[i] <= '0;
      end
      mod_in_r <= '0;
    end else if (!run) begin
      for (int i = 0; i < adrm_pkg::LAT_PAD; i++) begin
        dl_r[i] <= '0;
      end
      mod_in_r <= '0;
    end else if (ip_en) begin
      dl_r[0] <= interp;
      for (int i = 1; i < adrm_pkg::LAT_PAD; i++) begin
        dl_r[i] <= dl_r[i-1];
      end
      mod_in_r <= dl_r[adrm_pkg::LAT_PAD-1];
    end
  end

  // ----------------------------------------------------------------
  // modulator
  // ----------------------------------------------------------------
  adrm_dsm u_dsm (
    .clk(CLOCK),
    .rst_b(RST_B),
    .step(mod_en),
    .hold(!run),
    .x(mod_in_r),
    .level_r(MOD_LEVEL),
    .strobe_r(MOD_STROBE)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic probe_busy_r;
  logic [adrm_pkg::LAT_CW-1:0] probe_cnt_r;
  logic signed [adrm_pkg::DW-1:0] probe_val_r;

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      probe_busy_r <= 1'b0;
      probe_cnt_r <= '0;
      probe_val_r <= '0;
    end else if (!run) begin
      probe_busy_r <= 1'b0;
    end else if (!probe_busy_r && samp_en) begin
      probe_busy_r <= 1'b1;
      probe_cnt_r <= '0;
      probe_val_r <= SAMPLE_DATA;
    end else if (probe_busy_r && ip_en) begin
      probe_cnt_r <= probe_cnt_r + 1'b1;
      if (probe_cnt_r == adrm_pkg::LAT_CW'(adrm_pkg::LAT_TICKS - 1)) begin
        probe_busy_r <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  a_latency_exact: assert property (probe_busy_r && ip_en && run &&
      probe_cnt_r == adrm_pkg::LAT_CW'(adrm_pkg::LAT_TICKS - 1) |=> mod_in_r == probe_val_r)
    else $error("sample did not reach modulator after fixed latency");
  a_idle_midpoint: assert property (!run && !$past(run) |-> MOD_LEVEL == adrm_pkg::LVL_MID)
    else $error("output not at bipolar zero while invalid");
  a_ext_reset_enter: assert property (!ext_rst_n_r |=> st_r == adrm_pkg::ADRM_ST_RESET && !OUTPUT_VALID)
    else $error("external reset did not enter reset");
  a_init_full_count: assert property ($rose(run) |-> $past(init_cnt_r) == adrm_pkg::INIT_LAST && $past(sys_en))
    else $error("run entered before full initialisation count");
  a_init_to_run: assert property (st_r == adrm_pkg::ADRM_ST_INIT && ext_rst_n_r && sys_en &&
      init_cnt_r == adrm_pkg::INIT_LAST |=> run)
    else $error("initialisation end did not start conversion");
  a_count_restart: assert property (st_r == adrm_pkg::ADRM_ST_RESET |-> init_cnt_r == '0)
    else $error("initialisation count not cleared in reset");
  a_interp_phase: assert property (samp_en |-> ip_en && phase_r == adrm_pkg::PH_LAST)
    else $error("sample not on eighth interpolated tick");
  a_osr_ratio: assert property (ip_en |-> mod_en && ip_cnt_r == ip_last)
    else $error("modulator to interpolator ratio wrong");
  a_ratio_divider: assert property (mod_en && sel_r |-> mod_cnt_r == adrm_pkg::MOD_DIV_HI)
    else $error("256 fs divider wrong");
  a_clock_output: assert property (##1 1'b1 |-> ##[1:6] $changed(SYSTEM_CLOCK_OUTPUT))
    else $error("system clock output stalled");

  c_run_entered: cover property ($rose(run));
  c_reset_in_init: cover property (st_r == adrm_pkg::ADRM_ST_INIT && !ext_rst_n_r);
  c_ratio_high_run: cover property (run && sel_r && samp_en);
  c_latency_seen: cover property (probe_busy_r && probe_cnt_r == adrm_pkg::LAT_CW'(adrm_pkg::LAT_TICKS - 1) && ip_en);

endmodule

//--- shared/adrm_pkg.sv
// constants, state codes and rate figures shared by the converter digital path
// assumes one 100 MHz clock and a single-channel signed sample stream
//
// Notes on behaviour
// - sample to modulator input takes 11.125 sample periods at any rate.
// - during power-on reset the output is invalid and held at bipolar zero.
// - a low external reset input puts the device into reset; the partner drives it.
// - after reset release output stays at bipolar zero for 1024 system clocks.
// - modulator requantises to five levels with third-order noise shaping.
// - interpolator raises the sample rate eight times before the modulator.
// - modulator rate is 48 fs with 384 fs clock, 64 fs with 256 fs.
// - system clock is generated internally and driven on the system clock output.
// - ratio select low picks 384 fs, high picks 256 fs.
package adrm_pkg;

  // ----------------------------------------------------------------
  // clock and rates
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 100_000_000;
  localparam longint REF_HZ = 27_000_000;
  localparam longint FS_HZ = 48_000;
  localparam int NCO_W = 32;
  localparam int RATIO_LO = 384;
  localparam int RATIO_HI = 256;
  localparam logic [NCO_W-1:0] NCO_INC_LO = NCO_W'((FS_HZ * RATIO_LO * (64'h1 << NCO_W)) / CLK_HZ);
  localparam logic [NCO_W-1:0] NCO_INC_HI = NCO_W'((FS_HZ * RATIO_HI * (64'h1 << NCO_W)) / CLK_HZ);
  localparam int OSR_INTERP = 8;
  localparam int OSR_MOD_LO = 48;
  localparam int OSR_MOD_HI = 64;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] MOD_DIV_LO = CNT_W'(RATIO_LO / OSR_MOD_LO - 1);
  localparam logic [CNT_W-1:0] MOD_DIV_HI = CNT_W'(RATIO_HI / OSR_MOD_HI - 1);
  localparam logic [CNT_W-1:0] IP_DIV_LO = CNT_W'(OSR_MOD_LO / OSR_INTERP - 1);
  localparam logic [CNT_W-1:0] IP_DIV_HI = CNT_W'(OSR_MOD_HI / OSR_INTERP - 1);
  localparam logic [CNT_W-1:0] PH_LAST = CNT_W'(OSR_INTERP - 1);
  localparam int PH_SHIFT = 3;

  // ----------------------------------------------------------------
  // latency and initialisation
  // ----------------------------------------------------------------
  localparam int LAT_MILLI = 11125;
  localparam int LAT_TICKS = LAT_MILLI * OSR_INTERP / 1000;
  localparam int LAT_PAD = LAT_TICKS - OSR_INTERP;
  localparam int LAT_CW = 7;
  localparam int INIT_CYC = 1024;
  localparam int INIT_W = 10;
  localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(INIT_CYC - 1);

  // ----------------------------------------------------------------
  // data and modulator
  // ----------------------------------------------------------------
  localparam int DW = 16;
  localparam int LVL_W = 3;
  localparam logic [LVL_W-1:0] LVL_MID = 3'h2;
  localparam logic [LVL_W-1:0] LVL_MAX = 3'h4;
  localparam int DSM_W = 24;
  localparam int DSM_QSH = 14;
  localparam logic signed [DSM_W-1:0] DSM_AMP = 24'sh000002;
  localparam logic signed [DSM_W-1:0] DSM_HALF = 24'sh002000;
  localparam logic signed [DSM_W-1:0] DSM_ERR_LIM = 24'sh008000;

  typedef enum logic [2:0] {
    ADRM_ST_RESET = 3'h1,
    ADRM_ST_INIT = 3'h2,
    ADRM_ST_RUN = 3'h4
  } adrm_state_t;

endpackage
